//--- src/mpsc_map.svh
// register offsets, field positions and reset values for the mixer/pll/sync config bank
`ifndef MPSC_MAP_SVH
`define MPSC_MAP_SVH
`define MPSC_ADDR_W 7
`define MPSC_OFS_PHASE_CORR_CD 7'h11
`define MPSC_OFS_OSC_OFS_AB 7'h12
`define MPSC_OFS_OSC_OFS_CD 7'h13
`define MPSC_OFS_FREQ_AB_LO 7'h14
`define MPSC_OFS_FREQ_AB_HI 7'h15
`define MPSC_OFS_FREQ_CD_LO 7'h16
`define MPSC_OFS_FREQ_CD_HI 7'h17
`define MPSC_OFS_SYNTH_CTL 7'h18
`define MPSC_OFS_SYNTH_DIV 7'h19
`define MPSC_OFS_SLEEP 7'h1a
`define MPSC_OFS_REF_FUSE 7'h1b
`define MPSC_OFS_RSVD_A 7'h1c
`define MPSC_OFS_RSVD_B 7'h1d
`define MPSC_OFS_CORR_SYNC 7'h1e
`define MPSC_OFS_MIX_SYNC 7'h1f
`define MPSC_RST_ZERO 16'h0000
`define MPSC_RST_SYNTH_CTL 16'h2808
`define MPSC_RST_SYNTH_DIV 16'h0440
`define MPSC_RST_SLEEP 16'h0020
`define MPSC_RST_CORR_SYNC 16'h1111
`define MPSC_RST_MIX_SYNC 16'h1140
`define MPSC_CTL_WMASK 16'h1cf8
`define MPSC_DIV_WMASK 16'hfffc
`define MPSC_SLEEP_WMASK 16'hfcff
`define MPSC_REF_WMASK 16'h883f
`define MPSC_PCORR_WMASK 16'h0fff
`define MPSC_SRC_SW 3
`define MPSC_SRC_PIN 2
`define MPSC_SRC_STROBE 1
`define MPSC_SRC_AUTO 0
`define MPSC_DF_FRAME 2'h0
`define MPSC_DF_PIN 2'h1
`endif

//--- src/mpsc_pkg.sv
// types for the mixer/pll/sync config bank
package mpsc_pkg;
  typedef struct packed {
    logic [6:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } mpsc_bus_req_type;

  typedef struct packed {
    logic sync_pin;
    logic strobe_pin;
    logic frame;
  } mpsc_sync_in_type;

  typedef struct packed {
    logic [11:0] cd_phase_correction;
    logic [10:0] cd_gain_c;
    logic [15:0] cd_gain_delay;
  } mpsc_corr_type;

  typedef struct packed {
    logic [15:0] ab_osc_offset;
    logic [31:0] ab_freq_word;
    logic [15:0] cd_osc_offset;
    logic [31:0] cd_freq_word;
  } mpsc_mixer_type;

  typedef struct packed {
    logic loop_reset;
    logic ndiv_sync_ena;
    logic synth_ena;
    logic [1:0] charge_pump_select;
    logic [3:0] prescale_div;
    logic [8:0] m_div;
    logic [4:0] n_div;
    logic [1:0] vco_bias;
    logic [5:0] vco_coarse;
  } mpsc_pll_type;

  typedef struct packed {
    logic bias_sleep;
    logic tsense_sleep;
    logic pll_sleep;
    logic clkrecv_sleep;
    logic conv_a_powerdown;
    logic conv_b_powerdown;
    logic conv_c_powerdown;
    logic conv_d_powerdown;
    logic extref_ena;
    logic fuse_sleep;
  } mpsc_power_type;

  typedef struct packed {
    logic corr_ab_load;
    logic corr_cd_load;
    logic offset_ab_load;
    logic offset_cd_load;
    logic mixer_ab_load;
    logic mixer_cd_load;
    logic osc_acc_sync;
    logic formatter_sync;
    logic ndiv_sync;
  } mpsc_sync_out_type;

  typedef enum logic [1:0] {
    MPSC_PUMP_OFF = 2'b00,
    MPSC_PUMP_SINGLE = 2'b01,
    MPSC_PUMP_UNUSED = 2'b10,
    MPSC_PUMP_DUAL = 2'b11
  } mpsc_pump_type;

  typedef struct packed {
    logic [15:0] pcorr_cd;
    logic [15:0] osc_ofs_ab;
    logic [15:0] osc_ofs_cd;
    logic [15:0] freq_ab_lo;
    logic [15:0] freq_ab_hi;
    logic [15:0] freq_cd_lo;
    logic [15:0] freq_cd_hi;
    logic [15:0] synth_ctl;
    logic [15:0] synth_div;
    logic [15:0] sleep;
    logic [15:0] ref_fuse;
    logic [15:0] corr_sync;
    logic [15:0] mix_sync;
    logic [2:0] pin_sync_s;
    logic [2:0] pin_sync_q;
    logic [2:0] pin_strobe_s;
    logic [2:0] pin_strobe_q;
    logic [2:0] pin_frame_s;
    logic [2:0] pin_frame_q;
    logic [2:0] lfv_s;
    logic [2:0] lfv_q;
    logic [2:0] lfv_q2;
    logic [15:0] rdata;
    mpsc_corr_type corr_act;
    mpsc_mixer_type mix_act;
    mpsc_pll_type pll;
    mpsc_power_type pwr;
    mpsc_sync_out_type sync;
    logic [15:0] sync_pulse_pad;
  } mpsc_state_type;
endpackage

//--- src/mpsc_config_bank.sv
// mixer, pll and sync-select configuration register bank
//
// Operation
// - cd phase correction is 12-bit signed fraction
// - auto-sync loads cd gain, delay, phase together
// - ab offset added to accumulator upper 16
// - ab offset write loads offset and frequency
// - cd offset write loads offset and frequency
// - frequency word 32-bit split across two halves
// - loop reset holds filter at zero
// - divider sync enable uses sync pin, resets one
// - synthesizer enable selects pll or bypass
// - charge pump select decoded off/single/dual
// - prescaler codes 1..7, zero means 8
// - loop filter voltage 3-bit read-only status
// - m divider direct or doubled by top bit
// - n divider equals code plus one
// - sleep bits power down their blocks
// - reference select internal zero, external one
// - four-source select for cd correction, three-source for offset and ab correction
// - mixer and accumulator sync source layouts
// - formatter takes single coded sync source
// - software sync bit drives internal sync level
`timescale 1ns/1ps
`include "mpsc_map.svh"
module mpsc_config_bank (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire mpsc_pkg::mpsc_bus_req_type bus_req,
  output logic [15:0] bus_rdata,
  // correction shadow inputs from the neighbouring c/d gain and delay words
  input wire logic [10:0] cd_gain_c_shadow,
  input wire logic [15:0] cd_gain_delay_shadow,
  // sync pins and pll status, asynchronous
  input wire mpsc_pkg::mpsc_sync_in_type sync_in,
  input wire logic [2:0] loop_filter_level,
  // outputs to the datapath and analog
  output mpsc_pkg::mpsc_corr_type corr_active,
  output mpsc_pkg::mpsc_mixer_type mixer_active,
  output mpsc_pkg::mpsc_pll_type pll_cfg,
  output mpsc_pkg::mpsc_power_type power_cfg,
  output mpsc_pkg::mpsc_sync_out_type sync_out
);
  import mpsc_pkg::*;

  mpsc_state_type s_r;
  mpsc_state_type s_nxt;

  // which event sources hit a four-bit select field
  function automatic logic sel_hit(input logic [3:0] sel, input logic [3:0] ev);
    sel_hit = |(sel & ev);
  endfunction

  // masked register update, reserved bits keep their defaults
  function automatic logic [15:0] wr_masked(input logic [15:0] old, input logic [15:0] d, input logic [15:0] m);
    wr_masked = (old & ~m) | (d & m);
  endfunction

  // m divider: top bit doubles the low seven
  function automatic logic [8:0] m_decode(input logic [7:0] f);
    m_decode = f[7] ? {1'b0, f[6:0], 1'b0} : {2'b00, f[6:0]};
  endfunction

  // three-stage pin filter: a change counts when stages two and three agree
  function automatic logic pin_level(input logic [2:0] s, input logic q);
    pin_level = (s[1] == s[2]) ? s[2] : q;
  endfunction

  logic wr_hit;
  logic sw_sync;
  logic auto_corr_cd;
  logic auto_ofs_ab;
  logic auto_ofs_cd;
  logic [3:0] ev_corr_cd;
  logic [3:0] ev_mix_ab;
  logic [3:0] ev_mix_cd;
  logic [3:0] ev_nco;
  logic pin_sync_lvl;
  logic pin_strobe_lvl;
  logic pin_frame_lvl;
  logic sync_edge;
  logic strobe_edge;
  logic frame_edge;
  logic sw_edge;
  logic sw_prev;
  logic [1:0] df_sel;
  logic [2:0] lfv;

  always_comb begin
    s_nxt = s_r;
    wr_hit = bus_req.wr;
    // pin synchronisers
    s_nxt.pin_sync_s = {s_r.pin_sync_s[1:0], sync_in.sync_pin};
    s_nxt.pin_strobe_s = {s_r.pin_strobe_s[1:0], sync_in.strobe_pin};
    s_nxt.pin_frame_s = {s_r.pin_frame_s[1:0], sync_in.frame};
    pin_sync_lvl = pin_level(s_r.pin_sync_s, s_r.pin_sync_q[0]);
    pin_strobe_lvl = pin_level(s_r.pin_strobe_s, s_r.pin_strobe_q[0]);
    pin_frame_lvl = pin_level(s_r.pin_frame_s, s_r.pin_frame_q[0]);
    s_nxt.pin_sync_q = {2'b00, pin_sync_lvl};
    s_nxt.pin_strobe_q = {2'b00, pin_strobe_lvl};
    s_nxt.pin_frame_q = {s_r.pin_frame_q[1], s_r.sync_pulse_pad[0], pin_frame_lvl};
    sync_edge = pin_sync_lvl & ~s_r.pin_sync_q[0];
    strobe_edge = pin_strobe_lvl & ~s_r.pin_strobe_q[0];
    frame_edge = pin_frame_lvl & ~s_r.pin_frame_q[0];
    // loop filter status word, same three-stage filter on the whole 3-bit word
    s_nxt.lfv_s = loop_filter_level;
    s_nxt.lfv_q = s_r.lfv_s;
    s_nxt.lfv_q2 = s_r.lfv_q;
    lfv = (s_r.lfv_q == s_r.lfv_q2) ? s_r.lfv_q2 : s_r.synth_ctl[2:0];
    s_nxt.synth_ctl[2:0] = lfv;
    // software sync follows the bit; its rising edge is the event
    sw_sync = s_r.mix_sync[1];
    sw_prev = s_r.sync_pulse_pad[1];
    sw_edge = sw_sync & ~sw_prev;
    s_nxt.sync_pulse_pad = {14'h0000, sw_sync, 1'b0};
    auto_corr_cd = wr_hit && bus_req.addr == `MPSC_OFS_PHASE_CORR_CD;
    auto_ofs_ab = wr_hit && bus_req.addr == `MPSC_OFS_OSC_OFS_AB;
    auto_ofs_cd = wr_hit && bus_req.addr == `MPSC_OFS_OSC_OFS_CD;
    // register writes
    if (wr_hit) begin
      case (bus_req.addr)
        `MPSC_OFS_PHASE_CORR_CD: s_nxt.pcorr_cd = bus_req.wdata & `MPSC_PCORR_WMASK;
        `MPSC_OFS_OSC_OFS_AB: s_nxt.osc_ofs_ab = bus_req.wdata;
        `MPSC_OFS_OSC_OFS_CD: s_nxt.osc_ofs_cd = bus_req.wdata;
        `MPSC_OFS_FREQ_AB_LO: s_nxt.freq_ab_lo = bus_req.wdata;
        `MPSC_OFS_FREQ_AB_HI: s_nxt.freq_ab_hi = bus_req.wdata;
        `MPSC_OFS_FREQ_CD_LO: s_nxt.freq_cd_lo = bus_req.wdata;
        `MPSC_OFS_FREQ_CD_HI: s_nxt.freq_cd_hi = bus_req.wdata;
        `MPSC_OFS_SYNTH_CTL: s_nxt.synth_ctl = wr_masked(s_r.synth_ctl, bus_req.wdata, `MPSC_CTL_WMASK);
        `MPSC_OFS_SYNTH_DIV: s_nxt.synth_div = wr_masked(s_r.synth_div, bus_req.wdata, `MPSC_DIV_WMASK);
        `MPSC_OFS_SLEEP: s_nxt.sleep = wr_masked(s_r.sleep, bus_req.wdata, `MPSC_SLEEP_WMASK);
        `MPSC_OFS_REF_FUSE: s_nxt.ref_fuse = wr_masked(s_r.ref_fuse, bus_req.wdata, `MPSC_REF_WMASK);
        `MPSC_OFS_CORR_SYNC: s_nxt.corr_sync = bus_req.wdata;
        `MPSC_OFS_MIX_SYNC: s_nxt.mix_sync = {bus_req.wdata[15:1], 1'b0};
        default: s_nxt.rdata = s_r.rdata; // reserved and unmapped writes ignored
      endcase
    end
    if (wr_hit && bus_req.addr == `MPSC_OFS_SYNTH_CTL) begin
      s_nxt.synth_ctl[2:0] = lfv; // status field not writable
    end
    // read data, valid the cycle after the strobe
    s_nxt.rdata = 16'h0000;
    if (bus_req.rd) begin
      case (bus_req.addr)
        `MPSC_OFS_PHASE_CORR_CD: s_nxt.rdata = s_r.pcorr_cd;
        `MPSC_OFS_OSC_OFS_AB: s_nxt.rdata = s_r.osc_ofs_ab;
        `MPSC_OFS_OSC_OFS_CD: s_nxt.rdata = s_r.osc_ofs_cd;
        `MPSC_OFS_FREQ_AB_LO: s_nxt.rdata = s_r.freq_ab_lo;
        `MPSC_OFS_FREQ_AB_HI: s_nxt.rdata = s_r.freq_ab_hi;
        `MPSC_OFS_FREQ_CD_LO: s_nxt.rdata = s_r.freq_cd_lo;
        `MPSC_OFS_FREQ_CD_HI: s_nxt.rdata = s_r.freq_cd_hi;
        `MPSC_OFS_SYNTH_CTL: s_nxt.rdata = s_r.synth_ctl;
        `MPSC_OFS_SYNTH_DIV: s_nxt.rdata = s_r.synth_div;
        `MPSC_OFS_SLEEP: s_nxt.rdata = s_r.sleep;
        `MPSC_OFS_REF_FUSE: s_nxt.rdata = s_r.ref_fuse;
        `MPSC_OFS_RSVD_A: s_nxt.rdata = `MPSC_RST_ZERO;
        `MPSC_OFS_RSVD_B: s_nxt.rdata = `MPSC_RST_ZERO;
        `MPSC_OFS_CORR_SYNC: s_nxt.rdata = s_r.corr_sync;
        `MPSC_OFS_MIX_SYNC: s_nxt.rdata = s_r.mix_sync;
        default: s_nxt.rdata = 16'h0000;
      endcase
    end
    // sync events: software, pin, strobe, auto/frame
    ev_corr_cd = {sw_edge, sync_edge, strobe_edge, auto_corr_cd};
    ev_mix_ab = {sw_edge, sync_edge, strobe_edge, auto_ofs_ab};
    ev_mix_cd = {sw_edge, sync_edge, strobe_edge, auto_ofs_cd};
    ev_nco = {sw_edge, sync_edge, strobe_edge, frame_edge};
    s_nxt.sync.corr_ab_load = sel_hit(s_r.corr_sync[7:4], {sw_edge, sync_edge, strobe_edge, 1'b0});
    s_nxt.sync.corr_cd_load = sel_hit(s_r.corr_sync[3:0], ev_corr_cd);
    s_nxt.sync.offset_ab_load = sel_hit(s_r.corr_sync[15:12], {sw_edge, sync_edge, strobe_edge, 1'b0});
    s_nxt.sync.offset_cd_load = sel_hit(s_r.corr_sync[11:8], {sw_edge, sync_edge, strobe_edge, 1'b0});
    s_nxt.sync.mixer_ab_load = sel_hit(s_r.mix_sync[15:12], ev_mix_ab);
    s_nxt.sync.mixer_cd_load = sel_hit(s_r.mix_sync[11:8], ev_mix_cd);
    s_nxt.sync.osc_acc_sync = sel_hit(s_r.mix_sync[7:4], ev_nco);
    df_sel = s_r.mix_sync[3:2];
    case (df_sel)
      `MPSC_DF_FRAME: s_nxt.sync.formatter_sync = frame_edge;
      `MPSC_DF_PIN: s_nxt.sync.formatter_sync = sync_edge;
      default: s_nxt.sync.formatter_sync = 1'b0;
    endcase
    s_nxt.sync.ndiv_sync = s_r.synth_ctl[11] & sync_edge;
    // shadow-to-active loads, whole group in one cycle; the auto event
    // uses the value written in this same cycle
    if (sel_hit(s_r.corr_sync[3:0], ev_corr_cd)) begin
      s_nxt.corr_act.cd_phase_correction = auto_corr_cd ? bus_req.wdata[11:0] : s_r.pcorr_cd[11:0];
      s_nxt.corr_act.cd_gain_c = cd_gain_c_shadow;
      s_nxt.corr_act.cd_gain_delay = cd_gain_delay_shadow;
    end
    if (sel_hit(s_r.mix_sync[15:12], ev_mix_ab)) begin
      s_nxt.mix_act.ab_osc_offset = auto_ofs_ab ? bus_req.wdata : s_r.osc_ofs_ab;
      s_nxt.mix_act.ab_freq_word = {s_r.freq_ab_hi, s_r.freq_ab_lo};
    end
    if (sel_hit(s_r.mix_sync[11:8], ev_mix_cd)) begin
      s_nxt.mix_act.cd_osc_offset = auto_ofs_cd ? bus_req.wdata : s_r.osc_ofs_cd;
      s_nxt.mix_act.cd_freq_word = {s_r.freq_cd_hi, s_r.freq_cd_lo};
    end
    // pll decode
    s_nxt.pll.loop_reset = s_r.synth_ctl[12];
    s_nxt.pll.ndiv_sync_ena = s_r.synth_ctl[11];
    s_nxt.pll.synth_ena = s_r.synth_ctl[10];
    case (mpsc_pump_type'(s_r.synth_ctl[7:6]))
      MPSC_PUMP_SINGLE: s_nxt.pll.charge_pump_select = MPSC_PUMP_SINGLE;
      MPSC_PUMP_DUAL: s_nxt.pll.charge_pump_select = MPSC_PUMP_DUAL;
      default: s_nxt.pll.charge_pump_select = MPSC_PUMP_OFF;
    endcase
    s_nxt.pll.prescale_div = (s_r.synth_ctl[5:3] == 3'h0) ? 4'h8 : {1'b0, s_r.synth_ctl[5:3]};
    s_nxt.pll.m_div = m_decode(s_r.synth_div[15:8]);
    s_nxt.pll.n_div = {1'b0, s_r.synth_div[7:4]} + 5'h01;
    s_nxt.pll.vco_bias = s_r.synth_div[3:2];
    s_nxt.pll.vco_coarse = s_r.sleep[15:10];
    // power and reference
    s_nxt.pwr.bias_sleep = s_r.sleep[7];
    s_nxt.pwr.tsense_sleep = s_r.sleep[6];
    s_nxt.pwr.pll_sleep = s_r.sleep[5];
    s_nxt.pwr.clkrecv_sleep = s_r.sleep[4];
    s_nxt.pwr.conv_a_powerdown = s_r.sleep[3];
    s_nxt.pwr.conv_b_powerdown = s_r.sleep[2];
    s_nxt.pwr.conv_c_powerdown = s_r.sleep[1];
    s_nxt.pwr.conv_d_powerdown = s_r.sleep[0];
    s_nxt.pwr.extref_ena = s_r.ref_fuse[15];
    s_nxt.pwr.fuse_sleep = s_r.ref_fuse[11];
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.synth_ctl <= `MPSC_RST_SYNTH_CTL;
      s_r.synth_div <= `MPSC_RST_SYNTH_DIV;
      s_r.sleep <= `MPSC_RST_SLEEP;
      s_r.corr_sync <= `MPSC_RST_CORR_SYNC;
      s_r.mix_sync <= `MPSC_RST_MIX_SYNC;
      s_r.pll.ndiv_sync_ena <= 1'b1;
      s_r.pll.prescale_div <= 4'h1;
      s_r.pll.m_div <= 9'h004;
      s_r.pll.n_div <= 5'h05;
      s_r.pwr.pll_sleep <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus_rdata = s_r.rdata;
  assign corr_active = s_r.corr_act;
  assign mixer_active = s_r.mix_act;
  assign pll_cfg = s_r.pll;
  assign power_cfg = s_r.pwr;
  assign sync_out = s_r.sync;
endmodule

//--- testbench/mpsc_config_bank_asserts.sv
// concurrent checks for the mixer/pll/sync config bank
`timescale 1ns/1ps
`include "mpsc_map.svh"
module mpsc_config_bank_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire mpsc_pkg::mpsc_bus_req_type bus_req,
  input wire logic [15:0] bus_rdata,
  // shadow and status inputs
  input wire logic [10:0] cd_gain_c_shadow,
  input wire logic [15:0] cd_gain_delay_shadow,
  input wire mpsc_pkg::mpsc_sync_in_type sync_in,
  input wire logic [2:0] loop_filter_level,
  // block outputs
  input wire mpsc_pkg::mpsc_corr_type corr_active,
  input wire mpsc_pkg::mpsc_mixer_type mixer_active,
  input wire mpsc_pkg::mpsc_pll_type pll_cfg,
  input wire mpsc_pkg::mpsc_power_type power_cfg,
  input wire mpsc_pkg::mpsc_sync_out_type sync_out
);
  import mpsc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // mirror of the two sync-select registers
  logic [15:0] mix_sel_r;
  logic [15:0] corr_sel_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mix_sel_r <= `MPSC_RST_MIX_SYNC;
      corr_sel_r <= `MPSC_RST_CORR_SYNC;
    end else if (bus_req.wr) begin
      if (bus_req.addr == `MPSC_OFS_MIX_SYNC) mix_sel_r <= bus_req.wdata;
      if (bus_req.addr == `MPSC_OFS_CORR_SYNC) corr_sel_r <= bus_req.wdata;
    end
  end
  sequence wr_at(logic [6:0] a);
    bus_req.wr && bus_req.addr == a;
  endsequence
  ab_auto_load_a:
  assert property (wr_at(`MPSC_OFS_OSC_OFS_AB) ##0 mix_sel_r[12] |=> sync_out.mixer_ab_load &&
    mixer_active.ab_osc_offset == $past(bus_req.wdata)) else $error("ab offset write did not load mixer");
  cd_auto_load_a:
  assert property (wr_at(`MPSC_OFS_OSC_OFS_CD) ##0 mix_sel_r[8] |=> sync_out.mixer_cd_load &&
    mixer_active.cd_osc_offset == $past(bus_req.wdata)) else $error("cd offset write did not load mixer");
  ab_hold_a:
  assert property (!sync_out.mixer_ab_load |-> $stable(mixer_active.ab_freq_word) &&
    $stable(mixer_active.ab_osc_offset)) else $error("ab mixer changed without load");
  cd_hold_a:
  assert property (!sync_out.mixer_cd_load |-> $stable(mixer_active.cd_freq_word) &&
    $stable(mixer_active.cd_osc_offset)) else $error("cd mixer changed without load");
  corr_load_a:
  assert property (wr_at(`MPSC_OFS_PHASE_CORR_CD) ##0 corr_sel_r[0] |=> sync_out.corr_cd_load &&
    corr_active.cd_phase_correction == $past(bus_req.wdata[11:0]) &&
    corr_active.cd_gain_c == $past(cd_gain_c_shadow)) else $error("cd correction load wrong");
  ctl_decode_a:
  assert property (wr_at(`MPSC_OFS_SYNTH_CTL) |=> ##1 {pll_cfg.loop_reset, pll_cfg.ndiv_sync_ena,
    pll_cfg.synth_ena, pll_cfg.charge_pump_select} == {$past(bus_req.wdata[12:10], 2),
    (($past(bus_req.wdata[7:6], 2) == 2'h2) ? 2'h0 : $past(bus_req.wdata[7:6], 2))}
    && pll_cfg.prescale_div == (($past(bus_req.wdata[5:3], 2) == 3'h0) ? 4'h8 : {1'b0, $past(bus_req.wdata[5:3], 2)}))
    else $error("pll control decode wrong");
  div_decode_a:
  assert property (wr_at(`MPSC_OFS_SYNTH_DIV) |=> ##1 pll_cfg.m_div == ($past(bus_req.wdata[15], 2) ?
    {1'b0, $past(bus_req.wdata[14:8], 2), 1'b0} : {2'h0, $past(bus_req.wdata[14:8], 2)}) &&
    pll_cfg.n_div == {1'b0, $past(bus_req.wdata[7:4], 2)} + 5'h01 && pll_cfg.vco_bias == $past(bus_req.wdata[3:2], 2))
    else $error("divider decode wrong");
  sleep_decode_a:
  assert property (wr_at(`MPSC_OFS_SLEEP) |=> ##1 power_cfg[9:2] == $past(bus_req.wdata[7:0], 2) &&
    pll_cfg.vco_coarse == $past(bus_req.wdata[15:10], 2)) else $error("sleep decode wrong");
  ref_decode_a:
  assert property (wr_at(`MPSC_OFS_REF_FUSE) |=> ##1 power_cfg[1:0] ==
    {$past(bus_req.wdata[15], 2), $past(bus_req.wdata[11], 2)}) else $error("reference decode wrong");
  fmt_off_a:
  assert property (mix_sel_r[3] |-> !sync_out.formatter_sync) else $error("formatter synced while disabled");
endmodule
bind mpsc_config_bank mpsc_config_bank_asserts u_asserts (.mclk(mclk), .nrst(nrst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .cd_gain_c_shadow(cd_gain_c_shadow), .cd_gain_delay_shadow(cd_gain_delay_shadow),
  .sync_in(sync_in), .loop_filter_level(loop_filter_level), .corr_active(corr_active),
  .mixer_active(mixer_active), .pll_cfg(pll_cfg), .power_cfg(power_cfg), .sync_out(sync_out));

//--- testbench/test_mpsc_config_bank.sv
// self-checking bench for the mixer/pll/sync config bank
`timescale 1ns/1ps
`include "mpsc_map.svh"
`define CHK(g, e, m) check_val(64'(g), 64'(e), m)
module test_mpsc_config_bank;
  import mpsc_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  mpsc_bus_req_type bus_req = '0;
  logic [15:0] bus_rdata;
  logic [10:0] gain_c = 11'h5a3;
  logic [15:0] gain_dly = 16'hc0de;
  mpsc_sync_in_type sync_in = '0;
  logic [2:0] lfv = 3'h5;
  mpsc_corr_type corr_active;
  mpsc_mixer_type mixer_active;
  mpsc_pll_type pll_cfg;
  mpsc_power_type power_cfg;
  mpsc_sync_out_type sync_out;
  int bad_count = 0;
  int n_compared = 0;
  logic [15:0] rst_v [15] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h280d, 16'h0440, 16'h0020,
    16'h0, 16'h0, 16'h0, 16'h1111, 16'h1140};
  logic [7:0] m_tab [4] = '{8'h04, 8'h7f, 8'h84, 8'hff};
  logic [8:0] m_exp [4] = '{9'h004, 9'h07f, 9'h008, 9'h0fe};
  // pulses per sync_out bit, msb corr_ab_load down to ndiv_sync
  int pc [9] = '{default: 0};
  int base [9];
  logic [8:0] exp_pulse = 9'b111011111;
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    for (int b = 0; b < 9; b++) pc[b] += int'(sync_out[b]);
  end
  mpsc_config_bank dut (.mclk(mclk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .cd_gain_c_shadow(gain_c), .cd_gain_delay_shadow(gain_dly), .sync_in(sync_in), .loop_filter_level(lfv),
    .corr_active(corr_active), .mixer_active(mixer_active), .pll_cfg(pll_cfg), .power_cfg(power_cfg),
    .sync_out(sync_out));
  task automatic check_val(input logic [63:0] got, input logic [63:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    @(posedge mclk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    `CHK(bus_rdata, e, "readback");
  endtask
  // k: 0 frame, 1 strobe pin, 2 sync pin
  task automatic pin(input int k);
    @(posedge mclk);
    sync_in[k] <= 1'b1;
    repeat (4) @(posedge mclk);
    sync_in[k] <= 1'b0;
    tick(8);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    tick(4);
    `CHK({pll_cfg.ndiv_sync_ena, pll_cfg.m_div, pll_cfg.n_div, power_cfg.pll_sleep}, {1'h1, 9'h004, 5'h05, 1'h1}, "rst");
    for (int i = 0; i < 15; i++) rd(7'h11 + 7'(i), rst_v[i]);
    for (int g = 0; g < 2; g++) begin
      wr(7'h14 + 7'(2 * g), 16'h1234 + 16'(g));
      wr(7'h15 + 7'(2 * g), 16'h8765);
      tick();
      `CHK(g ? mixer_active.cd_freq_word : mixer_active.ab_freq_word, 32'h0, "halves alone");
      wr(7'h12 + 7'(g), 16'hfedc - 16'(g));
      tick();
      `CHK(g ? mixer_active.cd_freq_word : mixer_active.ab_freq_word, {16'h8765, 16'h1234 + 16'(g)}, "freq");
      `CHK(g ? mixer_active.cd_osc_offset : mixer_active.ab_osc_offset, 16'hfedc - 16'(g), "offset");
    end
    wr(`MPSC_OFS_PHASE_CORR_CD, 16'hf801);
    tick();
    `CHK(corr_active, {12'h801, gain_c, gain_dly}, "correction");
    rd(`MPSC_OFS_PHASE_CORR_CD, 16'h0801);
    for (int p = 0; p < 8; p++) begin
      wr(`MPSC_OFS_SYNTH_CTL, {3'h0, 3'(p), 2'h0, 2'(p), 3'(p), 3'h7});
      tick();
      `CHK(pll_cfg.prescale_div, (p == 0) ? 4'h8 : 4'(p), "prescale");
      `CHK({pll_cfg.loop_reset, pll_cfg.ndiv_sync_ena, pll_cfg.synth_ena, pll_cfg.charge_pump_select},
        {3'(p), (2'(p) == 2'h2) ? 2'h0 : 2'(p)}, "ctl");
      rd(`MPSC_OFS_SYNTH_CTL, {3'h1, 3'(p), 2'h0, 2'(p), 3'(p), 3'h5});
    end
    for (int i = 0; i < 4; i++) begin
      wr(`MPSC_OFS_SYNTH_DIV, {m_tab[i], 4'(i * 5), 4'h7});
      tick();
      `CHK({pll_cfg.m_div, pll_cfg.n_div, pll_cfg.vco_bias}, {m_exp[i], 5'(i * 5) + 5'h01, 2'h1}, "div");
      rd(`MPSC_OFS_SYNTH_DIV, {m_tab[i], 4'(i * 5), 4'h4});
    end
    wr(`MPSC_OFS_SLEEP, 16'hffff);
    tick();
    `CHK({power_cfg[9:2], pll_cfg.vco_coarse}, 14'h3fff, "sleep");
    rd(`MPSC_OFS_SLEEP, 16'hfcff);
    wr(`MPSC_OFS_REF_FUSE, 16'hffff);
    tick();
    `CHK(power_cfg[1:0], 2'h3, "ref fuse");
    rd(`MPSC_OFS_REF_FUSE, 16'h883f);
    wr(`MPSC_OFS_RSVD_A, 16'hffff);
    rd(`MPSC_OFS_RSVD_A, 16'h0000);
    rd(7'h05, 16'h0000);
    wr(`MPSC_OFS_MIX_SYNC, 16'h4240);
    wr(`MPSC_OFS_CORR_SYNC, 16'h2144);
    wr(`MPSC_OFS_FREQ_AB_LO, 16'haaaa);
    wr(`MPSC_OFS_FREQ_CD_LO, 16'hbbbb);
    wr(`MPSC_OFS_OSC_OFS_AB, 16'h1111);
    wr(`MPSC_OFS_PHASE_CORR_CD, 16'h0123);
    base = pc;
    pin(0);
    `CHK({mixer_active.ab_osc_offset, corr_active.cd_phase_correction}, {16'hfedc, 12'h801}, "no load");
    pin(2);
    `CHK({mixer_active.ab_freq_word, mixer_active.ab_osc_offset}, {32'h8765aaaa, 16'h1111}, "pin load");
    `CHK(corr_active.cd_phase_correction, 12'h123, "pin corr");
    `CHK(mixer_active.cd_freq_word, 32'h87651235, "cd waits");
    pin(1);
    `CHK(mixer_active.cd_freq_word, 32'h8765bbbb, "strobe load");
    for (int b = 0; b < 9; b++) `CHK(pc[b] - base[b], exp_pulse[b], "pulse count");
    wr(`MPSC_OFS_MIX_SYNC, 16'h8008);
    wr(`MPSC_OFS_FREQ_AB_HI, 16'h0f0f);
    wr(`MPSC_OFS_MIX_SYNC, 16'h800b);
    tick(8);
    `CHK(mixer_active.ab_freq_word, 32'h0f0faaaa, "sw sync");
    rd(`MPSC_OFS_MIX_SYNC, 16'h800a);
    wr(`MPSC_OFS_MIX_SYNC, 16'h8008);
    results();
  end
  initial begin
    #(40 * 4000);
    bad_count++;
    results();
  end
endmodule
